// file: dv/rsc_chk.sv
// port-level assertion checker for the reset source controller
`timescale 1ns/1ns
module rsc_chk #(
    parameter int unsigned POR_DELAY_CYC = 1,
    parameter int unsigned OSC_FAIL_CYC  = 1,
    parameter int unsigned MON_ON_CYC    = 1
) (
    // clock and reset
    input wire logic                  mclk_i,
    input wire logic                  nrst_i,
    // host port
    input wire rsc_pkg::rsc_host_req_t host_req_i,
    input wire logic [7:0]            host_rdata_o,
    // status inputs and pin
    input wire logic                  supply_ok_i,
    input wire logic                  clk_fail_i,
    input wire logic                  osc_ready_i,
    input wire logic                  reset_pin_n_i,
    input wire logic                  reset_pin_n_o,
    input wire logic                  reset_pin_n_oe_o,
    // chip controls
    input wire rsc_pkg::rsc_pad_ctl_t  pad_ctl_o,
    input wire logic                  osc_init_irq_o,
    input wire logic                  self_init_start_o,
    input wire logic                  monitor_on_o
);
    logic [9:0] hi_cnt_reg;     // cycles the pin has been high, saturating
    logic       pin_cause_reg;  // last reset was started by the pin
    logic       pwr_cause_reg;  // last reset was power class

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    // track pin high time and the class of the reset in progress
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hi_cnt_reg    <= 10'h000;
            pin_cause_reg <= 1'b0;
            pwr_cause_reg <= 1'b1;
        end else begin
            hi_cnt_reg <= !reset_pin_n_i ? 10'h000 : hi_cnt_reg + {9'h000, ~&hi_cnt_reg};
            if ($rose(pad_ctl_o.dev_rst)) begin
                pin_cause_reg <= !reset_pin_n_i && !reset_pin_n_oe_o;
                pwr_cause_reg <= reset_pin_n_oe_o;
            end
            if ($rose(reset_pin_n_oe_o)) begin
                pwr_cause_reg <= 1'b1;
            end
        end
    end

    pads_in_rst_a: assert property (pad_ctl_o.dev_rst |-> pad_ctl_o.dig_hiz &&
        pad_ctl_o.ana_hiz && pad_ctl_o.int_en_all) else $error("pads not parked in reset");
    pin_drive_a: assert property (reset_pin_n_oe_o |-> !reset_pin_n_o &&
        pad_ctl_o.dev_rst) else $error("pin driven outside reset");
    soft_exit_a: assert property ($rose(pad_ctl_o.dev_rst) && pad_ctl_o.osc_en
        |=> !pad_ctl_o.dev_rst && self_init_start_o) else $error("soft reset did not exit");
    soft_no_irq_a: assert property ($rose(pad_ctl_o.dev_rst) && pad_ctl_o.osc_en
        |-> !osc_init_irq_o [*4]) else $error("oscillator irq after soft reset");
    exit_pulse_a: assert property (self_init_start_o |-> $fell(pad_ctl_o.dev_rst)
        ##1 !self_init_start_o) else $error("self init pulse off reset exit");
    osc_irq_a: assert property ($rose(osc_ready_i) && pad_ctl_o.dev_rst
        |-> ##[1:6] osc_init_irq_o) else $error("no irq after oscillator settled");
    pin_delay_a: assert property ($rose(pad_ctl_o.osc_en) && pin_cause_reg
        |-> hi_cnt_reg >= 10'd500 && hi_cnt_reg <= 10'd510) else $error("pin exit delay wrong");
    mon_after_a: assert property (self_init_start_o
        |-> monitor_on_o == pwr_cause_reg) else $error("monitor enable wrong after reset");
    soft_zero_a: assert property (host_req_i.rd && !pad_ctl_o.dev_rst &&
        host_req_i.addr == rsc_pkg::ADDR_SOFT_RST |=> host_rdata_o == 8'h00)
        else $error("soft reset register not zero");
endmodule : rsc_chk

bind rsc_top rsc_chk #(.POR_DELAY_CYC(POR_DELAY_CYC), .OSC_FAIL_CYC(OSC_FAIL_CYC),
    .MON_ON_CYC(MON_ON_CYC)) chk_u (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .host_req_i(host_req_i), .host_rdata_o(host_rdata_o), .supply_ok_i(supply_ok_i),
    .clk_fail_i(clk_fail_i), .osc_ready_i(osc_ready_i), .reset_pin_n_i(reset_pin_n_i),
    .reset_pin_n_o(reset_pin_n_o), .reset_pin_n_oe_o(reset_pin_n_oe_o),
    .pad_ctl_o(pad_ctl_o), .osc_init_irq_o(osc_init_irq_o),
    .self_init_start_o(self_init_start_o), .monitor_on_o(monitor_on_o));

// file: dv/rsc_far_model.sv
// far side model: pulled-up open-drain reset pin and a crystal that settles
`timescale 1ns/1ns
module rsc_far_model #(
    parameter int SETTLE_CYC = 10
) (
    // clock
    input  wire logic mclk_i,
    // requests from device and board
    input  wire logic osc_en_i,
    input  wire logic pin_oe_i,
    input  wire logic ext_low_i,
    // levels back to the device
    output logic      osc_ready_o,
    output logic      pin_level_o
);
    int settle_cnt = 0;  // cycles the crystal has run

    // pull-up wins unless someone pulls the line low
    assign pin_level_o = !(pin_oe_i || ext_low_i);
    // crystal reports settled only after running a while, drops on the first clock edge after it is stopped
    assign osc_ready_o = (settle_cnt == SETTLE_CYC);

    // settle counter
    always @(posedge mclk_i) begin
        if (!osc_en_i) begin
            settle_cnt <= 0;
        end else if (settle_cnt < SETTLE_CYC) begin
            settle_cnt <= settle_cnt + 1;
        end
    end
endmodule : rsc_far_model

// file: dv/test_reset_source_controller.sv
// self-checking bench for the reset source controller
`timescale 1ns/1ns
module test_reset_source_controller;
    logic                   mclk_i       = 1'b0;
    logic                   nrst_i       = 1'b0;
    logic                   supply_ok_i  = 1'b1;
    logic                   clk_fail_i   = 1'b0;
    logic                   ext_low      = 1'b0;  // board pulls the pin low
    rsc_pkg::rsc_host_req_t host_req_i   = '0;
    logic [7:0]             host_rdata_o;
    logic                   osc_ready;
    logic                   pin_level;
    logic                   pin_drv;
    logic                   pin_oe;
    rsc_pkg::rsc_pad_ctl_t  pad_ctl_o;
    logic                   osc_irq;
    logic                   monitor_on_o;
    int                     error_cnt    = 0;
    int                     total_checks = 0;
    int                     cyc_cnt      = 0;
    int                     irq_cnt      = 0;

    // clock, 8 ns period
    always #4 mclk_i = ~mclk_i;

    rsc_top #(.POR_DELAY_CYC(50), .OSC_FAIL_CYC(30), .MON_ON_CYC(20)) dut_u (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .host_req_i(host_req_i),
        .host_rdata_o(host_rdata_o), .supply_ok_i(supply_ok_i), .clk_fail_i(clk_fail_i),
        .osc_ready_i(osc_ready), .reset_pin_n_i(pin_level), .reset_pin_n_o(pin_drv),
        .reset_pin_n_oe_o(pin_oe), .pad_ctl_o(pad_ctl_o), .osc_init_irq_o(osc_irq),
        .self_init_start_o(), .monitor_on_o(monitor_on_o));

    rsc_far_model #(.SETTLE_CYC(10)) far_u (.mclk_i(mclk_i), .osc_en_i(pad_ctl_o.osc_en),
        .pin_oe_i(pin_oe), .ext_low_i(ext_low), .osc_ready_o(osc_ready),
        .pin_level_o(pin_level));

    // count oscillator irq pulses and cut a hang short
    always @(posedge mclk_i) begin
        irq_cnt <= irq_cnt + (osc_irq === 1'b1 ? 1 : 0);
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one write strobe, set off the sampling edge
    task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        host_req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk_i);
        host_req_i <= '0;
    endtask : host_wr

    // one read strobe, data compared once the answering edge has passed
    task automatic host_rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk_i);
        host_req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk_i);
        host_req_i <= '0;
        chk($sformatf("read %h", a), exp, host_rdata_o);
    endtask : host_rd

    // bounded wait for the internal reset to reach a level
    task automatic wait_rst(input logic lvl, input int lim);
        int n;
        n = 0;
        while (pad_ctl_o.dev_rst !== lvl && n < lim) begin
            @(negedge mclk_i);
            n++;
        end
        chk("dev_rst", {7'h00, lvl}, {7'h00, pad_ctl_o.dev_rst});
    endtask : wait_rst

    task automatic t_power_on();
        wait_rst(1'b0, 600);
        host_rd(rsc_pkg::ADDR_SRC_SEL, 8'h06);
        host_rd(rsc_pkg::ADDR_CAUSE, 8'h02);
        host_rd(rsc_pkg::ADDR_MON_CTL, 8'hc0);
        host_rd(8'h40, 8'h00);
    endtask : t_power_on

    task automatic t_soft();
        int irq0;
        irq0 = irq_cnt;
        host_wr(rsc_pkg::ADDR_SOFT_RST, 8'h04);
        wait_rst(1'b1, 4);
        chk("osc_en", 8'h01, {7'h00, pad_ctl_o.osc_en});
        chk("pin_oe", 8'h00, {7'h00, pin_oe});
        wait_rst(1'b0, 4);
        host_wr(rsc_pkg::ADDR_CAUSE, 8'hff);
        host_rd(rsc_pkg::ADDR_CAUSE, 8'h04);
        host_rd(rsc_pkg::ADDR_MON_CTL, 8'h00);
        host_rd(rsc_pkg::ADDR_SOFT_RST, 8'h00);
        chk("irq count", irq0[7:0], irq_cnt[7:0]);
    endtask : t_soft

    task automatic t_soft_off();
        host_wr(rsc_pkg::ADDR_SRC_SEL, 8'h00);
        host_wr(rsc_pkg::ADDR_SOFT_RST, 8'h04);
        repeat (8) @(negedge mclk_i);
        chk("dev_rst", 8'h00, {7'h00, pad_ctl_o.dev_rst});
        host_rd(rsc_pkg::ADDR_SRC_SEL, 8'h00);
    endtask : t_soft_off

    task automatic t_pin();
        ext_low <= 1'b1;
        wait_rst(1'b1, 10);
        chk("pin_oe", 8'h00, {7'h00, pin_oe});
        repeat (20) @(negedge mclk_i);
        ext_low <= 1'b0;
        wait_rst(1'b0, 1000);
        host_rd(rsc_pkg::ADDR_CAUSE, 8'h01);
        host_rd(rsc_pkg::ADDR_SRC_SEL, 8'h04);
    endtask : t_pin

    task automatic t_power_fail();
        host_wr(rsc_pkg::ADDR_MON_CTL, 8'h80);
        repeat (30) @(negedge mclk_i);
        host_wr(rsc_pkg::ADDR_SRC_SEL, 8'h06);
        host_rd(rsc_pkg::ADDR_MON_CTL, 8'hc0);
        supply_ok_i <= 1'b0;
        wait_rst(1'b1, 10);
        repeat (2) @(negedge mclk_i);
        chk("pin level", 8'h00, {7'h00, pin_level});
        chk("osc_en", 8'h00, {7'h00, pad_ctl_o.osc_en});
        repeat (20) @(negedge mclk_i);
        supply_ok_i <= 1'b1;
        wait_rst(1'b0, 600);
        host_rd(rsc_pkg::ADDR_CAUSE, 8'h02);
        chk("monitor_on", 8'h01, {7'h00, monitor_on_o});
    endtask : t_power_fail

    task automatic t_clk_fail();
        int irq0;
        irq0 = irq_cnt;
        clk_fail_i <= 1'b1;
        wait_rst(1'b1, 10);
        chk("pin_oe", 8'h01, {7'h00, pin_oe});
        clk_fail_i <= 1'b0;
        wait_rst(1'b0, 600);
        host_rd(rsc_pkg::ADDR_CAUSE, 8'h02);
        chk("irq count", irq0[7:0] + 8'h01, irq_cnt[7:0]);
    endtask : t_clk_fail

    // monitor selected before it has settled forces a power-class reset
    task automatic t_early_sel();
        host_wr(rsc_pkg::ADDR_SRC_SEL, 8'h04);
        host_wr(rsc_pkg::ADDR_MON_CTL, 8'h00);
        host_wr(rsc_pkg::ADDR_MON_CTL, 8'h80);
        host_wr(rsc_pkg::ADDR_SRC_SEL, 8'h06);
        wait_rst(1'b1, 10);
        wait_rst(1'b0, 600);
        host_rd(rsc_pkg::ADDR_CAUSE, 8'h02);
        host_rd(rsc_pkg::ADDR_SRC_SEL, 8'h06);
    endtask : t_early_sel

    // main sequence
    initial begin
        repeat (12) @(negedge mclk_i);
        nrst_i = 1'b1;
        t_power_on();
        t_soft();
        t_soft_off();
        t_pin();
        t_power_fail();
        t_clk_fail();
        t_early_sel();
        close_out();
    end
endmodule : test_reset_source_controller

// file: hdl/rsc_pkg.sv
// constants and types shared by the reset source controller
package rsc_pkg;

    // register offsets on the host port
    localparam logic [7:0] ADDR_MON_CTL   = 8'h13;
    localparam logic [7:0] ADDR_SRC_SEL   = 8'h72;
    localparam logic [7:0] ADDR_CAUSE     = 8'h73;
    localparam logic [7:0] ADDR_SOFT_RST  = 8'h75;

    // field positions
    localparam int MON_EN_BIT    = 7;
    localparam int MON_LVL_BIT   = 6;
    localparam int SEL_SOFT_BIT  = 2;
    localparam int SEL_PF_BIT    = 1;
    localparam int SOFT_GO_BIT   = 2;

    // reset values
    localparam logic [7:0] MON_CTL_RST    = 8'h00;
    localparam logic [7:0] SRC_SEL_RST    = 8'h04;
    localparam logic [7:0] SRC_SEL_POWER  = 8'h06;
    localparam logic [7:0] CAUSE_RST      = 8'h00;
    localparam logic [7:0] CAUSE_SOFT     = 8'h04;
    localparam logic [7:0] CAUSE_POWER    = 8'h02;
    localparam logic [7:0] CAUSE_PIN      = 8'h01;

    // timing, in printed units, and clock rate
    localparam int CLK_MHZ       = 125;
    localparam int POR_DELAY_MS  = 5;
    localparam int OSC_FAIL_MS   = 1;
    localparam int PIN_EXIT_US   = 4;
    localparam int MON_ON_US     = 100;

    // timing in clock cycles
    localparam int POR_DELAY_CYC = POR_DELAY_MS * 1000 * CLK_MHZ;
    localparam int OSC_FAIL_CYC  = OSC_FAIL_MS * 1000 * CLK_MHZ;
    localparam int PIN_EXIT_CYC  = PIN_EXIT_US * CLK_MHZ;
    localparam int MON_ON_CYC    = MON_ON_US * CLK_MHZ;

    // timer width, enough for the longest count
    localparam int TMR_W = 20;

    // sequencer states
    typedef enum logic [2:0] {
        ST_HOLD,
        ST_WAIT,
        ST_OSC,
        ST_SOFT,
        ST_RUN
    } rsc_state_t;

    // cause of the reset in progress
    typedef enum logic [2:0] {
        SRC_POR,
        SRC_PF,
        SRC_OSCF,
        SRC_PIN,
        SRC_SOFT
    } rsc_src_t;

    // one host port access, same clock as the block
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsc_host_req_t;

    // pad and chip controls driven during and after reset
    typedef struct packed {
        logic dig_hiz;
        logic ana_hiz;
        logic osc_en;
        logic dev_rst;
        logic int_en_all;
    } rsc_pad_ctl_t;

endpackage : rsc_pkg

// file: hdl/rsc_sync.sv
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ns
module rsc_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         mclk_i,
    input  wire logic         nrst_i,
    // levels in and out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;  // first stage, may settle late

    // two stages on every edge; only the second stage leaves the module
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= '0;
            sync_o   <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule : rsc_sync

// file: hdl/rsc_timer.sv
// loadable down counter for reset durations
`timescale 1ns/1ns
module rsc_timer (
    // clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    nrst_i,
    // load control
    input  wire logic                    load_i,
    input  wire logic [rsc_pkg::TMR_W-1:0] load_val_i,
    // expiry
    output logic                         done_o
);
    logic [rsc_pkg::TMR_W-1:0] cnt_reg;  // remaining cycles
    logic [rsc_pkg::TMR_W-1:0] cnt_next; // next count

    // load wins, otherwise count down to zero and stop
    assign cnt_next = load_i ? load_val_i :
                      (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    assign done_o   = (cnt_reg == '0) && !load_i;

    // count register
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : rsc_timer

// file: hdl/rsc_top.sv
// reset source sequencer with supply monitor and reset registers
`timescale 1ns/1ns
module rsc_top #(
    parameter int unsigned POR_DELAY_CYC = rsc_pkg::POR_DELAY_CYC,
    parameter int unsigned OSC_FAIL_CYC  = rsc_pkg::OSC_FAIL_CYC,
    parameter int unsigned MON_ON_CYC    = rsc_pkg::MON_ON_CYC
) (
    // clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  nrst_i,
    // host register port
    input  wire rsc_pkg::rsc_host_req_t host_req_i,
    output logic [7:0]                 host_rdata_o,
    // supply comparator, clock-fail detector, oscillator status
    input  wire logic                  supply_ok_i,
    input  wire logic                  clk_fail_i,
    input  wire logic                  osc_ready_i,
    // open-drain reset pin
    input  wire logic                  reset_pin_n_i,
    output logic                       reset_pin_n_o,
    output logic                       reset_pin_n_oe_o,
    // controls to pads and rest of chip
    output rsc_pkg::rsc_pad_ctl_t      pad_ctl_o,
    output logic                       osc_init_irq_o,
    output logic                       self_init_start_o,
    output logic                       monitor_on_o
);

    // synchronised pin-side levels
    logic [2:0] sync_lvl;     // {pin, clock fail, oscillator ready}
    logic       supply_s;     // supply above threshold
    logic       pin_high_s;   // reset pin reads high
    logic       clk_fail_s;   // system clock failed
    logic       osc_ready_s;  // oscillator settled

    // sequencer state
    rsc_pkg::rsc_state_t state_reg;
    rsc_pkg::rsc_state_t state_next;
    rsc_pkg::rsc_src_t   src_reg;
    rsc_pkg::rsc_src_t   src_next;

    // software visible registers and the internal oscillator-init flag
    logic [7:0] sel_reg;      // source select
    logic [7:0] sel_next;
    logic [7:0] cause_reg;    // cause of last reset
    logic [7:0] cause_next;
    logic       mon_en_reg;   // monitor enable
    logic       mon_en_next;
    logic       osc_done_reg; // oscillator init completed since reset
    logic       osc_done_next;

    // registered outputs
    rsc_pkg::rsc_pad_ctl_t pad_next;
    logic                  drive_next;
    logic                  irq_next;
    logic                  init_next;
    logic [7:0]            rdata_next;

    // timers
    logic                      tmr_load;
    logic [rsc_pkg::TMR_W-1:0] tmr_val;
    logic                      tmr_done;
    logic                      mon_stable;

    // decode wires
    logic       in_run;
    logic       power_src;
    logic       wr_ok;
    logic       wr_sel;
    logic       wr_mon;
    logic       wr_soft;
    logic       soft_req;
    logic       pf_trip;
    logic       pin_req;
    logic       osc_trip;
    logic [7:0] mon_rd;

    // all three pin-side inputs cross through two flops
    rsc_sync #(
        .W       (3)
    ) u_sync (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .async_i ({reset_pin_n_i, clk_fail_i, osc_ready_i}),
        .sync_o  (sync_lvl)
    );
    assign pin_high_s  = sync_lvl[2];
    assign clk_fail_s  = sync_lvl[1];
    assign osc_ready_s = sync_lvl[0];

    // supply comparator has its own synchroniser pair
    rsc_sync #(
        .W       (1)
    ) u_sync_sup (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .async_i (supply_ok_i),
        .sync_o  (supply_s)
    );

    // duration timer for the reset phases
    rsc_timer u_tmr (
        .mclk_i     (mclk_i),
        .nrst_i     (nrst_i),
        .load_i     (tmr_load),
        .load_val_i (tmr_val),
        .done_o     (tmr_done)
    );

    // monitor turn-on timer, restarted while the monitor is off
    rsc_timer u_mon_tmr (
        .mclk_i     (mclk_i),
        .nrst_i     (nrst_i),
        .load_i     (!mon_en_reg),
        .load_val_i (rsc_pkg::TMR_W'(MON_ON_CYC)),
        .done_o     (mon_stable)
    );

    // register access decode; host ignored until reset is fully released
    assign in_run    = (state_reg == rsc_pkg::ST_RUN);
    assign wr_ok     = host_req_i.wr && in_run;
    assign wr_sel    = wr_ok && (host_req_i.addr == rsc_pkg::ADDR_SRC_SEL);
    assign wr_mon    = wr_ok && (host_req_i.addr == rsc_pkg::ADDR_MON_CTL);
    assign wr_soft   = wr_ok && (host_req_i.addr == rsc_pkg::ADDR_SOFT_RST);
    assign power_src = (src_reg == rsc_pkg::SRC_POR) || (src_reg == rsc_pkg::SRC_PF)
                       || (src_reg == rsc_pkg::SRC_OSCF);

    // soft reset only when its source is selected
    assign soft_req  = wr_soft && host_req_i.wdata[rsc_pkg::SOFT_GO_BIT]
                       && sel_reg[rsc_pkg::SEL_SOFT_BIT];

    // monitor trips on low supply, or on being selected before it settles
    assign pf_trip   = in_run && mon_en_reg && sel_reg[rsc_pkg::SEL_PF_BIT]
                       && (!supply_s || !mon_stable);

    // clock failure counts only after oscillator init completed
    assign osc_trip  = in_run && osc_done_reg && clk_fail_s;

    // external pin pulled low by someone else
    assign pin_req   = in_run && !pin_high_s;

    // supply monitor control read view, reserved bits read zero
    assign mon_rd    = {mon_en_reg, supply_s & mon_en_reg, 6'h00};

    // sequencer next state, source and timer load
    always_comb begin
        state_next = state_reg;
        src_next   = src_reg;
        tmr_load   = 1'b0;
        tmr_val    = '0;
        unique case (state_reg)
            // held: power sources wait for supply, pin waits for release
            rsc_pkg::ST_HOLD: begin
                if (src_reg == rsc_pkg::SRC_PIN) begin
                    if (pin_high_s) begin
                        state_next = rsc_pkg::ST_WAIT;
                        tmr_load   = 1'b1;
                        tmr_val    = rsc_pkg::TMR_W'(rsc_pkg::PIN_EXIT_CYC);
                    end
                end else if (supply_s) begin
                    state_next = rsc_pkg::ST_WAIT;
                    tmr_load   = 1'b1;
                    tmr_val    = rsc_pkg::TMR_W'(POR_DELAY_CYC);
                end
            end
            // timed stay in reset; supply loss restarts the hold for power-on and power-fail sources
            rsc_pkg::ST_WAIT: begin
                if ((src_reg == rsc_pkg::SRC_POR || src_reg == rsc_pkg::SRC_PF)
                    && !supply_s) begin
                    state_next = rsc_pkg::ST_HOLD;
                end else if (tmr_done) begin
                    state_next = rsc_pkg::ST_OSC;
                end
            end
            // oscillator started, waiting for it to settle
            rsc_pkg::ST_OSC: begin
                if (osc_ready_s) begin
                    state_next = rsc_pkg::ST_RUN;
                end
            end
            // soft reset lasts a single cycle
            rsc_pkg::ST_SOFT: begin
                state_next = rsc_pkg::ST_RUN;
            end
            // running: watch the four run-time sources, power events first
            rsc_pkg::ST_RUN: begin
                if (pf_trip) begin
                    state_next = rsc_pkg::ST_HOLD;
                    src_next   = rsc_pkg::SRC_PF;
                end else if (osc_trip) begin
                    state_next = rsc_pkg::ST_WAIT;
                    src_next   = rsc_pkg::SRC_OSCF;
                    tmr_load   = 1'b1;
                    tmr_val    = rsc_pkg::TMR_W'(OSC_FAIL_CYC);
                end else if (pin_req) begin
                    state_next = rsc_pkg::ST_HOLD;
                    src_next   = rsc_pkg::SRC_PIN;
                end else if (soft_req) begin
                    state_next = rsc_pkg::ST_SOFT;
                    src_next   = rsc_pkg::SRC_SOFT;
                end
            end
        endcase
    end

    // register contents: defaults while in reset, host writes while running
    always_comb begin
        sel_next      = sel_reg;
        mon_en_next   = mon_en_reg;
        cause_next    = cause_reg;
        osc_done_next = osc_done_reg;
        if (!in_run) begin
            // power-class resets enable and select the monitor
            if (power_src) begin
                sel_next    = rsc_pkg::SRC_SEL_POWER;
                mon_en_next = 1'b1;
                cause_next  = rsc_pkg::CAUSE_POWER;
            end else begin
                sel_next    = rsc_pkg::SRC_SEL_RST;
                mon_en_next = rsc_pkg::MON_CTL_RST[rsc_pkg::MON_EN_BIT];
                cause_next  = (src_reg == rsc_pkg::SRC_SOFT) ? rsc_pkg::CAUSE_SOFT
                                                             : rsc_pkg::CAUSE_PIN;
            end
            // oscillator init complete only once it settles again
            if (src_reg != rsc_pkg::SRC_SOFT) begin
                osc_done_next = (state_reg == rsc_pkg::ST_OSC) && osc_ready_s;
            end
        end else begin
            // only bits 2 and 1 of the select register are writable
            if (wr_sel) begin
                sel_next = host_req_i.wdata
                           & ((8'h01 << rsc_pkg::SEL_SOFT_BIT)
                           | (8'h01 << rsc_pkg::SEL_PF_BIT));
            end
            // monitor enable bit
            if (wr_mon) begin
                mon_en_next = host_req_i.wdata[rsc_pkg::MON_EN_BIT];
            end
        end
    end

    // read mux, registered one cycle after the strobe
    always_comb begin
        rdata_next = host_rdata_o;
        if (host_req_i.rd && in_run) begin
            unique case (host_req_i.addr)
                rsc_pkg::ADDR_MON_CTL: rdata_next = mon_rd;
                rsc_pkg::ADDR_SRC_SEL: rdata_next = sel_reg;
                rsc_pkg::ADDR_CAUSE:   rdata_next = cause_reg;
                default:               rdata_next = 8'h00;
            endcase
        end
    end

    // pad and chip controls follow the next state
    always_comb begin
        pad_next.dig_hiz    = (state_next != rsc_pkg::ST_RUN);
        pad_next.ana_hiz    = (state_next != rsc_pkg::ST_RUN);
        pad_next.dev_rst    = (state_next != rsc_pkg::ST_RUN);
        pad_next.int_en_all = (state_next != rsc_pkg::ST_RUN);
        // oscillator stopped in hold and wait, kept on for soft reset
        pad_next.osc_en     = (state_next != rsc_pkg::ST_HOLD)
                              && (state_next != rsc_pkg::ST_WAIT);
        // pin driven low by power-class resets while held or timed
        drive_next          = ((state_next == rsc_pkg::ST_HOLD)
                              || (state_next == rsc_pkg::ST_WAIT))
                              && (src_next != rsc_pkg::SRC_PIN)
                              && (src_next != rsc_pkg::SRC_SOFT);
        // oscillator interrupt only after a settle step
        irq_next            = (state_reg == rsc_pkg::ST_OSC)
                              && (state_next == rsc_pkg::ST_RUN);
        // self-initialisation starts on every exit
        init_next           = (state_reg != rsc_pkg::ST_RUN)
                              && (state_next == rsc_pkg::ST_RUN);
    end

    // state and register flops; power-up starts as a power-on hold
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg    <= rsc_pkg::ST_HOLD;
            src_reg      <= rsc_pkg::SRC_POR;
            sel_reg      <= rsc_pkg::SRC_SEL_RST;
            cause_reg    <= rsc_pkg::CAUSE_RST;
            mon_en_reg   <= rsc_pkg::MON_CTL_RST[rsc_pkg::MON_EN_BIT];
            osc_done_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            src_reg      <= src_next;
            sel_reg      <= sel_next;
            cause_reg    <= cause_next;
            mon_en_reg   <= mon_en_next;
            osc_done_reg <= osc_done_next;
        end
    end

    // output flops; internal reset released on a clock edge
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pad_ctl_o         <= '{dig_hiz: 1'b1, ana_hiz: 1'b1, osc_en: 1'b0,
                                   dev_rst: 1'b1, int_en_all: 1'b1};
            reset_pin_n_oe_o  <= 1'b1;
            osc_init_irq_o    <= 1'b0;
            self_init_start_o <= 1'b0;
            host_rdata_o      <= 8'h00;
        end else begin
            pad_ctl_o         <= pad_next;
            reset_pin_n_oe_o  <= drive_next;
            osc_init_irq_o    <= irq_next;
            self_init_start_o <= init_next;
            host_rdata_o      <= rdata_next;
        end
    end

    // open-drain pin only ever pulls low
    assign reset_pin_n_o = 1'b0;
    assign monitor_on_o  = mon_en_reg;

endmodule : rsc_top
